// >>> core/adc_status_mode_regs.v
// Notes on behaviour
// - Status byte is read only
// - Status shifts out bit 7 first
// - Status reads 0x8C after reset
// - Ready flag low when result loaded
// - Ready flag high after data read or pre-update
// - Ready flag high on entering standby by config write
// - Serial output pin also shows ready
// - Error flag updates with ready flag on each new result
// - Error flag set on clamped result
// - Error flag cleared by conversion-starting write
// - Status bits 5:4 zero, 3:2 one
// - Status bits 1:0 show active input
// - Config byte read/write, select 01, resets 0x02
// - Config byte MSB first, fixed field layout
// - Config write restarts modulator, sets ready
// - Config controls coding, buffer, power-down
// - Command waits for zero gate bit, seven follow
// - Command bit 3 direction, bits 5:4 target
// - Input select encoding; change restarts filter
// - Mode select; single returns to power-down

`include "adc_regs_defs.vh"

`default_nettype none

module adc_status_mode_regs (
    input  wire        CLOCK_I,           // System clock, 200 MHz
    input  wire        NRST_I,            // Synchronous reset, active low
    input  wire        SCLK_I,            // Serial clock pin, idles high
    input  wire        DIN_I,             // Serial data in pin
    input  wire        CS_N_I,            // Chip select pin, active low
    input  wire        CONV_DONE_I,       // Pulse: new result loaded in data reg
    input  wire        CONV_CLAMP_I,      // With CONV_DONE_I: result clamped
    input  wire        PRE_UPDATE_I,      // Pulse: data reg about to be overwritten
    input  wire [23:0] DATA_I,            // Current data register contents
    output reg         DOUT_O,            // Shared serial out / ready pin level
    output reg         DOUT_OE_O,         // High while the pin is driven
    output reg  [1:0]  OPERATING_MODE_SELECT_O, // Mode select field
    output reg         BURNOUT_CURRENT_ENABLE_O,// Burnout sources on
    output reg         UNIPOLAR_O,        // Unipolar coding when high
    output reg         BUFFER_EN_O,       // Input buffer on
    output reg  [1:0]  INPUT_SELECT_O,    // Active input selection
    output reg         POWER_DOWN_O,      // Converter powered down
    output reg         RESTART_O          // Pulse: reset modulator and filter
);

    // Serial engine states
    localparam [1:0] ST_GATE  = 2'h0;     // Waiting for the zero gate bit
    localparam [1:0] ST_CMD   = 2'h1;     // Collecting seven command bits
    localparam [1:0] ST_WRITE = 2'h2;     // Shifting a register write in
    localparam [1:0] ST_READ  = 2'h3;     // Shifting a register read out

    // Reset image of the status byte; the ready flag starts from its top bit
    localparam [7:0] STATUS_INIT = `STATUS_RESET;

    // Bits moved by an access to a given register
    function [4:0] access_len;
        input [1:0] rsel;
        begin
            if (rsel == `RSEL_DATA) begin
                access_len = `LEN_DATA;
            end else begin
                access_len = `LEN_BYTE;
            end
        end
    endfunction

    // Synchronised pins and edge detection
    wire [2:0] pins_sync;                 // {cs_n, sclk, din} after two flops
    wire       cs_n_s   = pins_sync[2];   // Chip select, synced
    wire       sclk_s   = pins_sync[1];   // Serial clock, synced
    wire       din_s    = pins_sync[0];   // Data in, synced
    reg        sclk_d;                    // Previous synced serial clock
    wire       sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    wire       sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;

    pin_level_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk_i   (CLOCK_I),
        .rst_n_i (NRST_I),
        .async_i ({CS_N_I, SCLK_I, DIN_I}),
        .sync_o  (pins_sync)
    );

    // Register state
    reg  [1:0]  state;                    // Serial engine state
    reg  [4:0]  bit_cnt;                  // Bits moved in this phase
    reg  [4:0]  bit_len;                  // Length of the current access
    reg  [5:0]  cmd_shift;                // First six command bits; the seventh is taken live
    reg  [1:0]  cur_rsel;                 // Target of the pending access
    reg  [7:0]  wr_shift;                 // Incoming write byte
    reg  [23:0] rd_shift;                 // Outgoing read bits, MSB at 23
    reg  [7:0]  op_config;                // Operating config storage
    reg  [1:0]  input_select;             // Active input selection
    reg         ready_n;                  // Ready flag, low = result waiting
    reg         err_flag;                 // Clamp error flag
    reg         single_busy;              // Single conversion in progress

    // Decoded views of the command byte as it completes: the last bit is
    // still on the data pin, so it is spliced in rather than read back
    wire [7:0]  cmd_byte  = {1'b0, cmd_shift, din_s};
    wire [1:0]  cmd_rsel  = cmd_byte[`CMD_RSEL_HI:`CMD_RSEL_LO];
    wire        cmd_read  = cmd_byte[`CMD_DIR_BIT];
    wire [1:0]  cmd_sel   = cmd_byte[`CMD_SEL_HI:`CMD_SEL_LO];
    wire [7:0]  next_wr   = {wr_shift[6:0], din_s};

    // Status byte; fixed markers never depend on state
    wire [7:0]  status_byte = {ready_n, err_flag, 2'h0,
                               `STATUS_FIXED, input_select};

    // Events raised by the serial engine this cycle
    wire cmd_done   = (state == ST_CMD) && sclk_rise &&
                      (bit_cnt == `LEN_COMMAND - 5'h01);
    wire write_done = (state == ST_WRITE) && sclk_rise &&
                      (bit_cnt == bit_len - 5'h01);
    wire read_done  = (state == ST_READ) && sclk_rise &&
                      (bit_cnt == bit_len - 5'h01);
    wire mode_write = write_done && (cur_rsel == `RSEL_MODE);
    wire data_read  = read_done && (cur_rsel == `RSEL_DATA);
    wire sel_change = cmd_done && (cmd_sel != input_select);

    // Mode byte about to be stored, reserved bits forced low
    wire [7:0] next_config = next_wr & `MODE_WRITE_MASK;
    wire [1:0] next_md     = next_config[`MODE_MD_HI:`MODE_MD_LO];

    // Edge history of the synced serial clock
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            sclk_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    // Serial engine: gate bit, command byte, then one register access
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            state     <= ST_GATE;
            bit_cnt   <= 5'h00;
            bit_len   <= `LEN_BYTE;
            cmd_shift <= 6'h00;
            cur_rsel  <= `RSEL_STATUS;
            wr_shift  <= 8'h00;
            rd_shift  <= 24'h000000;
        end else if (cs_n_s) begin
            // Deselect abandons any partial access
            state   <= ST_GATE;
            bit_cnt <= 5'h00;
        end else if (sclk_rise) begin
            case (state)
                ST_GATE: begin
                    // Ones leave the engine parked on the gate bit
                    if (!din_s) begin
                        state   <= ST_CMD;
                        bit_cnt <= 5'h00;
                    end
                end
                ST_CMD: begin
                    cmd_shift <= {cmd_shift[4:0], din_s};
                    bit_cnt   <= bit_cnt + 5'h01;
                    if (bit_cnt == `LEN_COMMAND - 5'h01) begin
                        bit_cnt  <= 5'h00;
                        cur_rsel <= cmd_rsel;
                        bit_len  <= access_len(cmd_rsel);
                        if (cmd_read) begin
                            // Load the selected register, MSB first
                            state <= ST_READ;
                            case (cmd_rsel)
                                `RSEL_STATUS: begin
                                    rd_shift <= {status_byte, 16'h0000};
                                end
                                `RSEL_MODE: begin
                                    rd_shift <= {op_config, 16'h0000};
                                end
                                `RSEL_DATA: begin
                                    rd_shift <= DATA_I;
                                end
                                default: begin
                                    // Filter storage lives elsewhere
                                    rd_shift <= 24'h000000;
                                end
                            endcase
                        end else if (cmd_rsel == `RSEL_STATUS ||
                                     cmd_rsel == `RSEL_DATA) begin
                            // Command-only write; status is never a target
                            state <= ST_GATE;
                        end else begin
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    wr_shift <= next_wr;
                    bit_cnt  <= bit_cnt + 5'h01;
                    if (bit_cnt == bit_len - 5'h01) begin
                        state   <= ST_GATE;
                        bit_cnt <= 5'h00;
                    end
                end
                ST_READ: begin
                    rd_shift <= {rd_shift[22:0], 1'b0};
                    bit_cnt  <= bit_cnt + 5'h01;
                    if (bit_cnt == bit_len - 5'h01) begin
                        state   <= ST_GATE;
                        bit_cnt <= 5'h00;
                    end
                end
                default: begin
                    state   <= ST_GATE;
                    bit_cnt <= 5'h00;
                end
            endcase
        end
    end

    // Operating config storage and the fields it drives
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            op_config <= `MODE_RESET;
        end else if (mode_write) begin
            op_config <= next_config;
        end
    end

    // Field outputs follow the stored config one cycle later
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            OPERATING_MODE_SELECT_O  <= 2'h0;
            BURNOUT_CURRENT_ENABLE_O <= 1'b0;
            UNIPOLAR_O               <= 1'b0;
            BUFFER_EN_O              <= 1'b1;
        end else begin
            OPERATING_MODE_SELECT_O  <= op_config[`MODE_MD_HI:`MODE_MD_LO];
            BURNOUT_CURRENT_ENABLE_O <= op_config[`MODE_BURNOUT_BIT];
            UNIPOLAR_O               <= op_config[`MODE_UNIPOLAR_BIT];
            BUFFER_EN_O              <= op_config[`MODE_BUFFER_BIT];
        end
    end

    // Input selection is taken from every completed command byte
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            input_select   <= `SEL_RESET;
            INPUT_SELECT_O <= `SEL_RESET;
        end else begin
            if (cmd_done) begin
                input_select <= cmd_sel;
            end
            INPUT_SELECT_O <= input_select;
        end
    end

    // Restart pulse: config write or change of input selection
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            RESTART_O <= 1'b0;
        end else begin
            RESTART_O <= mode_write | sel_change;
        end
    end

    // Single conversion bookkeeping; a restart beats a finishing result
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            single_busy <= 1'b0;
        end else if (mode_write) begin
            single_busy <= (next_md == `OPMODE_SINGLE);
        end else if (sel_change) begin
            single_busy <= single_busy;
        end else if (CONV_DONE_I) begin
            single_busy <= 1'b0;
        end
    end

    // Power-down: standby codes, or single mode with nothing in flight
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            POWER_DOWN_O <= 1'b0;
        end else begin
            POWER_DOWN_O <= op_config[`MODE_MD_HI] |
                            ((op_config[`MODE_MD_HI:`MODE_MD_LO] == `OPMODE_SINGLE) &
                             ~single_busy);
        end
    end

    // Ready flag: a fresh result wins over any set event in the same cycle
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            // Taken from the status image so the two never disagree
            ready_n <= STATUS_INIT[7];
        end else if (CONV_DONE_I) begin
            ready_n <= 1'b0;
        end else if (data_read | PRE_UPDATE_I) begin
            ready_n <= 1'b1;
        end else if (mode_write) begin
            // Covers entry to standby as well as a config-write restart, not an input change
            ready_n <= 1'b1;
        end
    end

    // Error flag moves with the ready flag on each new result
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            err_flag <= 1'b0;
        end else if (CONV_DONE_I) begin
            err_flag <= CONV_CLAMP_I;
        end else if (mode_write | sel_change) begin
            err_flag <= 1'b0;
        end
    end

    // Shared output pin: read bits while shifting, otherwise the ready flag
    always @(posedge CLOCK_I) begin
        if (!NRST_I) begin
            DOUT_O    <= 1'b1;
            DOUT_OE_O <= 1'b0;
        end else if (cs_n_s) begin
            // Released while deselected so other parts can share the line
            DOUT_O    <= 1'b1;
            DOUT_OE_O <= 1'b0;
        end else begin
            DOUT_OE_O <= 1'b1;
            if (state == ST_READ) begin
                // New bit after a falling edge, stable at the next rise
                if (sclk_fall) begin
                    DOUT_O <= rd_shift[23];
                end
            end else begin
                DOUT_O <= ready_n;
            end
        end
    end

endmodule // adc_status_mode_regs

`default_nettype wire

// >>> core/adc_regs_defs.vh
`ifndef ADC_REGS_DEFS_VH
`define ADC_REGS_DEFS_VH

// Register select codes carried in the command byte
`define RSEL_STATUS        2'h0
`define RSEL_MODE          2'h1
`define RSEL_FILTER        2'h2
`define RSEL_DATA          2'h3

// Command byte field positions (the write-gate bit is shifted first)
`define CMD_RSEL_HI        5
`define CMD_RSEL_LO        4
`define CMD_DIR_BIT        3
`define CMD_SEL_HI         1
`define CMD_SEL_LO         0

// Reset values
`define STATUS_RESET       8'h8C
`define MODE_RESET         8'h02
`define SEL_RESET          2'h0

// Operating config field positions
`define MODE_MD_HI         7
`define MODE_MD_LO         6
`define MODE_BURNOUT_BIT   3
`define MODE_UNIPOLAR_BIT  2
`define MODE_BUFFER_BIT    1

// Mask of bits that are stored; the rest always read zero
`define MODE_WRITE_MASK    8'hCE

// Operating mode codes; both codes with the upper bit set mean standby
`define OPMODE_CONTINUOUS  2'h0
`define OPMODE_SINGLE      2'h1

// Fixed marker bits of the status byte
`define STATUS_FIXED       2'h3

// Transfer lengths in serial bits
`define LEN_COMMAND        5'h07
`define LEN_BYTE           5'h08
`define LEN_DATA           5'h18

`endif

// >>> core/pin_level_sync.v
`default_nettype none

// Two-flop synchroniser for a group of independent pin levels
module pin_level_sync #(
    parameter WIDTH = 3
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta;   // First stage, read only by the second stage

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // Each pin gets its own pair; they may resolve one cycle apart
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    meta[g]   <= 1'b1;
                    sync_o[g] <= 1'b1;
                end else begin
                    meta[g]   <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule // pin_level_sync

`default_nettype wire

// >>> verif/adc_status_mode_regs_checker.sv
`default_nettype none

module adc_status_mode_regs_checker (
    input wire logic       CLOCK_I,
    input wire logic       NRST_I,
    input wire logic       CS_N_I,
    input wire logic       CONV_DONE_I,
    input wire logic       DOUT_OE_O,
    input wire logic [1:0] OPERATING_MODE_SELECT_O,
    input wire logic       BURNOUT_CURRENT_ENABLE_O,
    input wire logic       UNIPOLAR_O,
    input wire logic       BUFFER_EN_O,
    input wire logic [1:0] INPUT_SELECT_O,
    input wire logic       POWER_DOWN_O,
    input wire logic       RESTART_O
);
    timeunit 1ns;
    timeprecision 1ps;

    // One clock domain, so clock and reset are given once
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);

    // Restart is a single-cycle strobe
    a_restart_pulse: assert property (RESTART_O |=> !RESTART_O)
        else $error("restart strobe longer than one cycle");
    // Pin released once chip select has been high past the synchroniser
    a_oe_release: assert property (CS_N_I [*4] |-> !DOUT_OE_O)
        else $error("output pin still driven with chip select high");
    a_oe_drive: assert property ((!CS_N_I) [*5] |-> DOUT_OE_O)
        else $error("output pin not driven with chip select low");
    // Standby codes put the converter to sleep within three cycles
    a_standby_entry: assert property ($rose(OPERATING_MODE_SELECT_O[1]) |-> ##[0:3] POWER_DOWN_O)
        else $error("standby mode without power-down");
    a_run_awake: assert property ((OPERATING_MODE_SELECT_O == 2'h0) [*6] |-> !POWER_DOWN_O)
        else $error("continuous mode while powered down");
    a_single_sleep: assert property (CONV_DONE_I && OPERATING_MODE_SELECT_O == 2'h1 |-> ##[1:3] POWER_DOWN_O)
        else $error("single conversion did not return to power-down");
    // Waking up is only ever caused by a write that restarts the filter
    a_wake_restart: assert property ($fell(POWER_DOWN_O)
        |-> RESTART_O || $past(RESTART_O) || $past(RESTART_O, 2) || $past(RESTART_O, 3))
        else $error("power-down left without restart");
    a_field_restart: assert property (($changed(UNIPOLAR_O) || $changed(BUFFER_EN_O)
        || $changed(BURNOUT_CURRENT_ENABLE_O) || $changed(INPUT_SELECT_O))
        |-> RESTART_O || $past(RESTART_O) || $past(RESTART_O, 2) || $past(RESTART_O, 3))
        else $error("configuration changed without restart");
    // A restart comes only from a serial access
    a_restart_cause: assert property (RESTART_O |-> !$past(CS_N_I, 4))
        else $error("restart outside a serial access");

    c_sleep: cover property ($rose(POWER_DOWN_O));
    c_restart: cover property (RESTART_O);
    c_single_done: cover property (CONV_DONE_I && OPERATING_MODE_SELECT_O == 2'h1);
endmodule // adc_status_mode_regs_checker

bind adc_status_mode_regs adc_status_mode_regs_checker u_chk (
    .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .CS_N_I(CS_N_I), .CONV_DONE_I(CONV_DONE_I),
    .DOUT_OE_O(DOUT_OE_O), .OPERATING_MODE_SELECT_O(OPERATING_MODE_SELECT_O),
    .BURNOUT_CURRENT_ENABLE_O(BURNOUT_CURRENT_ENABLE_O), .UNIPOLAR_O(UNIPOLAR_O),
    .BUFFER_EN_O(BUFFER_EN_O), .INPUT_SELECT_O(INPUT_SELECT_O),
    .POWER_DOWN_O(POWER_DOWN_O), .RESTART_O(RESTART_O)
);

`default_nettype wire

// >>> verif/serial_host_model.sv
`default_nettype none

// Host controller on the three-wire link; serial clock idles high between frames
module serial_host_model (
    output logic      SCLK,
    output logic      DIN,
    output logic      CS_N,
    input wire logic  DOUT
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        SCLK = 1'b1;
        DIN  = 1'b1;
        CS_N = 1'b1;
    end

    // Shift n bits MSB first: data set on the fall, sampled late in the low phase
    task automatic shift(input logic [23:0] w, input int n, output logic [23:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            SCLK = 1'b0;
            DIN  = w[i];
            #31 r = {r[22:0], DOUT};
            #1 SCLK = 1'b1;
            #32;
        end
    endtask

    // One framed access: optional idle ones, command byte, then n data bits
    task automatic access(input logic [7:0] cmd, input logic [23:0] wd, input int n, input int pre,
                          output logic [23:0] r);
        logic [23:0] t;
        CS_N = 1'b0;
        #40;
        shift(24'hFFFFFF, pre, t);          // Ones before the gate bit must be ignored
        shift({16'h0000, cmd}, 8, t);       // Gate bit 0, then direction and target
        shift(wd, n, r);
        #40 CS_N = 1'b1;
        DIN = ~DIN;                         // Released line never keeps its last value
        #100;
    endtask

    // Hold chip select low with no clocks and look at the ready level
    task automatic peek(output logic v);
        CS_N = 1'b0;
        #100 v = DOUT;
        CS_N = 1'b1;
        #100;
    endtask
endmodule // serial_host_model

`default_nettype wire

// >>> verif/adc_status_mode_regs_tb.sv
`default_nettype none

module adc_status_mode_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, nrst, sclk, din, cs_n, done, clamp, pre, dout, oe, burn, unip, buf_en, pd, restart, v;
    logic [1:0]  mode, sel;
    logic [23:0] data, rd;
    int          n_errors = 0;
    int          cmp_count = 0;

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    adc_status_mode_regs DUT (
        .CLOCK_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .DIN_I(din), .CS_N_I(cs_n),
        .CONV_DONE_I(done), .CONV_CLAMP_I(clamp), .PRE_UPDATE_I(pre), .DATA_I(data),
        .DOUT_O(dout), .DOUT_OE_O(oe), .OPERATING_MODE_SELECT_O(mode),
        .BURNOUT_CURRENT_ENABLE_O(burn), .UNIPOLAR_O(unip), .BUFFER_EN_O(buf_en),
        .INPUT_SELECT_O(sel), .POWER_DOWN_O(pd), .RESTART_O(restart)
    );

    serial_host_model host (.SCLK(sclk), .DIN(din), .CS_N(cs_n), .DOUT(dout));

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Converter event strobes, one cycle wide
    task automatic ev(input logic d, input logic c, input logic p);
        @(posedge clk);
        done  <= d;
        clamp <= c;
        pre   <= p;
        @(posedge clk);
        done  <= 1'b0;
        clamp <= 1'b0;
        pre   <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic rd_status(input logic [1:0] ch);
        host.access({6'h02, ch}, 24'h0, 8, 0, rd);
    endtask

    task automatic t_reset;
        chk({mode, burn, unip, buf_en, pd, sel}, 24'h08);
        host.access(8'h08, 24'h0, 8, 3, rd);
        chk(rd, 24'h8C);
        host.access(8'h00, 24'h0, 0, 0, rd);
        rd_status(2'h0);
        chk(rd, 24'h8C);
        host.access(8'h18, 24'h0, 8, 0, rd);
        chk(rd, 24'h02);
        $display("test reset done");
    endtask

    task automatic t_config;
        for (int m = 0; m < 4; m++) begin
            host.access(8'h10, {16'h0000, m[1:0], 6'h3F}, 8, 0, rd);
            host.access(8'h18, 24'h0, 8, 0, rd);
            chk(rd, {16'h0000, m[1:0], 6'h0E});
            chk({mode, burn, unip, buf_en, pd}, {m[1:0], 3'h7, m[1]});
        end
        host.access(8'h10, 24'h02, 8, 0, rd);
        chk({mode, burn, unip, buf_en, pd}, 24'h02);
        $display("test config done");
    endtask

    task automatic t_events;
        ev(1'b1, 1'b1, 1'b0);
        rd_status(2'h0);
        chk(rd, 24'h4C);
        host.peek(v);
        chk(v, 1'b0);
        ev(1'b0, 1'b0, 1'b1);
        rd_status(2'h0);
        chk(rd[7], 1'b1);
        ev(1'b1, 1'b0, 1'b0);
        rd_status(2'h0);
        chk(rd, 24'h0C);
        host.access(8'h38, 24'h0, 24, 0, rd);
        chk(rd, data);
        rd_status(2'h0);
        chk(rd, 24'h8C);
        ev(1'b1, 1'b1, 1'b0);
        host.access(8'h10, 24'h02, 8, 0, rd);
        rd_status(2'h0);
        chk(rd, 24'h8C);
        host.peek(v);
        chk(v, 1'b1);
        $display("test events done");
    endtask

    task automatic t_single;
        host.access(8'h10, 24'h42, 8, 0, rd);
        chk(pd, 1'b0);
        ev(1'b1, 1'b0, 1'b0);
        chk(pd, 1'b1);
        rd_status(2'h0);
        chk(rd, 24'h0C);
        host.access(8'h10, 24'hC2, 8, 0, rd);
        rd_status(2'h0);
        chk(rd, 24'h8C);
        host.access(8'h10, 24'h02, 8, 0, rd);
        $display("test single done");
    endtask

    task automatic t_select;
        for (int c = 0; c < 4; c++) begin
            host.access({6'h00, c[1:0]}, 24'h0, 0, 0, rd);
            chk(sel, c[1:0]);
            rd_status(c[1:0]);
            chk(rd, {16'h0000, 6'h23, c[1:0]});
        end
        host.access(8'h00, 24'h0, 0, 0, rd);
        $display("test select done");
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run needs well under 100 us of link traffic
    initial begin
        #200us;
        n_errors++;
        stop_test;
    end

    initial begin
        nrst  = 1'b0;
        done  = 1'b0;
        clamp = 1'b0;
        pre   = 1'b0;
        data  = 24'hA5C3E1;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        t_reset;
        t_config;
        t_events;
        t_single;
        t_select;
        stop_test;
    end
endmodule // adc_status_mode_regs_tb

`default_nettype wire
